// [bench/smc_slave_model.sv]
// Purpose: Behavioural external slave for master-mode runs, phase one modes.
// Assumes: Data sampled on the leading clock edge and changed on the trailing one.
// Notes:   MISO shows the inverse of its top register bit while deselected.
`timescale 1ns/1ps
module smc_slave_model #(
  parameter logic [15:0] REPLY = 16'h5AC3
) (
  input  wire logic        sclk_in,
  input  wire logic        pol_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic [15:0]      got_out
);
  logic [15:0] tx_q = 16'h0000;
  logic        sclk_lead;
  // The clock is folded with the polarity so that its leading edge always rises.
  assign sclk_lead = sclk_in ^ pol_in;
  always @(negedge cs_n_in) tx_q = REPLY;
  always @(posedge sclk_lead) if (!cs_n_in) got_out = {got_out[14:0], mosi_in};
  always @(negedge sclk_lead) if (!cs_n_in) tx_q = {tx_q[14:0], ~tx_q[15]};
  assign miso_out = cs_n_in ? ~tx_q[15] : tx_q[15];
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for the serial core in master and slave roles.
// Assumes: Inputs change at the falling edge of the core clock.
// Notes:   The slave model stands on chip select zero.
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, rst_n = 0, en = 0, mst = 1, pol = 0, pha = 1, psm = 1;
  logic        tx_v = 0, rxr = 0, str = 0;
  logic [3:0]  wb = 4'h0, msf = 4'hE, cs, cs_oe;
  logic [7:0]  div = 8'h08, dly = 8'h00;
  logic        tx_rdy, irq, dma, sck, sck_oe, mo, mo_oe, mi, mi_oe, s_mi;
  logic [15:0] rxd, got;
  smc_pkg::smc_tx_word_t tx_w = '0;
  smc_pkg::smc_status_t  st, ien = '0;
  int          fails = 0, samples_checked = 0, msk;
  always #4 clk = ~clk;
  smc_core dut (.core_clk_in(clk), .rst_n_in(rst_n), .enable_in(en),
    .master_select_in(mst), .clock_polarity_in(pol), .clock_phase_in(pha),
    .word_bits_in(wb), .baud_div_in(div), .inter_transfer_delay_in(dly),
    .peripheral_select_mode_in(psm), .mode_select_field_in(msf), .tx_valid_in(tx_v),
    .tx_word_in(tx_w), .tx_ready_out(tx_rdy), .rx_read_in(rxr), .status_read_in(str),
    .rx_data_out(rxd), .status_out(st), .irq_enable_in(ien), .irq_out(irq),
    .dma_tx_req_out(dma), .sclk_in(sck), .sclk_out(sck), .sclk_oe_n_out(sck_oe),
    .mosi_in(mo), .mosi_out(mo), .mosi_oe_n_out(mo_oe), .miso_in(mi_oe ? s_mi : mi),
    .miso_out(mi), .miso_oe_n_out(mi_oe), .cs0_in(cs_oe[0] | cs[0]), .cs_out(cs),
    .cs_oe_n_out(cs_oe));
  smc_slave_model partner (.sclk_in(sck), .pol_in(pol), .cs_n_in(cs_oe[0] | cs[0]), .mosi_in(mo),
    .miso_out(s_mi), .got_out(got));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [3:0] p, input logic [15:0] d);
    tx_w = '{peripheral_select_field: p, data: d};
    tx_v = 1'b1;
    while (tx_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input bit stat);
    if (stat) str = 1'b1;
    else rxr = 1'b1;
    @(negedge clk);
    if (stat) str = 1'b0;
    else rxr = 1'b0;
  endtask
  task automatic wait_st(input int b);
    for (int i = 0; i < 4000 && st[b] !== 1'b1; i++) @(negedge clk);
    if (st[b] !== 1'b1) fails++;
  endtask
  task automatic close_out();
    $display("counts fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    close_out();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(st, 4'hC);
    chk(cs, 4'hF);
    chk(irq, 1'b0);
    en = 1'b1;
    @(negedge clk);
    chk({cs_oe, sck_oe, mo_oe, mi_oe}, 7'h01);
    $display("test reset and master pins done");
    for (int n = 0; n <= 8; n += 8) begin
      wb = 4'(n);
      msk = (1 << (8 + n)) - 1;
      push(4'hE, 16'h9C36);
      tx_v = 1'b0;
      repeat (20) @(negedge clk);
      chk(cs, 4'hE);
      chk(dma, 1'b1);
      wait_st(1);
      chk(rxd, 16'h5AC3 >> (8 - n));
      chk(got & msk[15:0], 16'h9C36 & msk[15:0]);
      rd(0);
      chk(st.rx_full, 1'b0);
    end
    $display("test word lengths done");
    wb = 4'h0;
    ien = 4'h2;
    push(4'hE, 16'h0011);
    push(4'hE, 16'h0022);
    tx_v = 1'b0;
    repeat (3) @(negedge clk);
    chk(st.tx_holding_empty, 1'b0);
    wait_st(0);
    chk(st.rx_overrun, 1'b1);
    chk(rxd, 16'h005A);
    chk(irq, 1'b1);
    wait_st(2);
    chk(got[7:0], 8'h22);
    rd(1);
    chk(st.rx_overrun, 1'b0);
    rd(0);
    @(negedge clk);
    chk(irq, 1'b0);
    $display("test overrun and interrupt done");
    psm = 1'b0;
    msf = 4'hF;
    push(4'h0, 16'h0077);
    tx_v = 1'b0;
    repeat (200) @(negedge clk);
    chk(cs, 4'hF);
    chk(st.tx_holding_empty, 1'b0);
    msf = 4'hD;
    repeat (10) @(negedge clk);
    chk(cs, 4'hD);
    wait_st(1);
    chk(got[7:0], 8'h22);
    rd(0);
    msf = 4'hE;
    push(4'h0, 16'h0055);
    tx_v = 1'b0;
    wait_st(1);
    chk(rxd, 16'h005A);
    chk(got[7:0], 8'h55);
    rd(0);
    wait_st(2);
    $display("test select field done");
    pol = 1'b1;
    repeat (2) @(negedge clk);
    chk(sck, 1'b1);
    push(4'h0, 16'h00C6);
    tx_v = 1'b0;
    wait_st(1);
    chk(rxd, 16'h005A);
    chk(got[7:0], 8'hC6);
    rd(0);
    pol = 1'b0;
    $display("test clock polarity done");
    dly = 8'h01;
    push(4'h0, 16'h00A5);
    tx_v = 1'b0;
    wait_st(1);
    chk(rxd, 16'h005A);
    repeat (16) @(negedge clk);
    chk(st.tx_idle, 1'b0);
    repeat (24) @(negedge clk);
    chk(st.tx_idle, 1'b1);
    rd(0);
    dly = 8'h00;
    $display("test transfer delay done");
    mst = 1'b0;
    repeat (4) @(negedge clk);
    chk({cs_oe, sck_oe, mo_oe}, 6'h3F);
    $display("test slave pins done");
    close_out();
  end
endmodule

// [verilog/smc_core.sv]
// Purpose: Serial peripheral core working as bus master or slave.
// Assumes: Control inputs come from logic on core_clk_in; pins are asynchronous.
// Notes:   Output enables are active low; the bench resolves the shared wires.
// Behaviour
// RL1: Master select one drives clock, selects, MOSI.
// RL2: Master select zero: slave, MISO driven, clock input.
// RL3: Slave uses select zero; selects one-three undriven.
// RL4: Baud generator runs only in master mode.
// RL5: Polarity and phase choose launch/sample edges.
// RL6: Four modes from polarity and phase bits.
// RL7: Both ends share mode; master reconfigures per slave.
// RL8: Master drives addressed select and serial clock.
// RL9: Transmit holding, receive holding, one shift register.
// RL10: Transmit write starts master transfer immediately.
// RL11: Receive on every bit while transmitting.
// RL12: No transfer when select field selects nobody.
// RL13: Held word waits, then loads after transfer.
// RL14: Holding-empty sets on load, clears on write.
// RL15: Holding-empty flag requests transmit DMA.
// RL16: Idle flag sets once transfers have finished.
// RL17: Idle flag waits out nonzero inter-transfer delay.
// RL18: Receive-full sets on transfer, clears on read.
// RL19: New word before read sets overrun.
// RL20: Overrun blocks receive loads; status read clears.
// RL21: One interrupt request output.
// RL22: Select mode bit picks fixed or per-word select.
// RL23: Eight to sixteen bits per transfer.
// RL24: Slave waits for select low, counts configured bits.
// RL25: Interrupt follows enabled set status flags.
// RL26: Words travel most significant bit first.
`timescale 1ns/1ps
module smc_core #(
  parameter int FIFO_DEPTH = smc_pkg::SMC_FIFO_DEPTH
) (
  input  wire logic                           core_clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           enable_in,
  input  wire logic                           master_select_in,
  input  wire logic                           clock_polarity_in,
  input  wire logic                           clock_phase_in,
  input  wire logic [smc_pkg::SMC_BITS_W-1:0] word_bits_in,
  input  wire logic [smc_pkg::SMC_DIV_W-1:0]  baud_div_in,
  input  wire logic [smc_pkg::SMC_DLY_W-1:0]  inter_transfer_delay_in,
  input  wire logic                           peripheral_select_mode_in,
  input  wire logic [smc_pkg::SMC_PCS_W-1:0]  mode_select_field_in,
  input  wire logic                           tx_valid_in,
  input  wire smc_pkg::smc_tx_word_t          tx_word_in,
  output logic                                tx_ready_out,
  input  wire logic                           rx_read_in,
  input  wire logic                           status_read_in,
  output logic [smc_pkg::SMC_DATA_W-1:0]      rx_data_out,
  output smc_pkg::smc_status_t                status_out,
  input  wire smc_pkg::smc_status_t           irq_enable_in,
  output logic                                irq_out,
  output logic                                dma_tx_req_out,
  input  wire logic                           sclk_in,
  output logic                                sclk_out,
  output logic                                sclk_oe_n_out,
  input  wire logic                           mosi_in,
  output logic                                mosi_out,
  output logic                                mosi_oe_n_out,
  input  wire logic                           miso_in,
  output logic                                miso_out,
  output logic                                miso_oe_n_out,
  input  wire logic                           cs0_in,
  output logic [smc_pkg::SMC_PCS_W-1:0]       cs_out,
  output logic [smc_pkg::SMC_PCS_W-1:0]       cs_oe_n_out
);

  localparam int SN = smc_pkg::SMC_SYNC_N;
  localparam int IX_MISO = 0;
  localparam int IX_MOSI = 1;
  localparam int IX_SCLK = 2;
  localparam int IX_CS0  = 3;

  smc_pkg::smc_state_t   state_q;
  smc_pkg::smc_tx_word_t thr_q;
  smc_pkg::smc_tx_word_t fifo_word;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic [SN-1:0]         sync1_q;
  logic [SN-1:0]         sync2_q;
  logic                  sclk_prev_q;
  logic                  cs_prev_q;
  logic                  mst_q;
  logic                  tx_holding_empty_flag_q;
  logic                  tx_idle_q;
  logic                  rx_full_q;
  logic                  ovr_q;
  logic [15:0]           sh_q;
  logic [15:0]           rx_q;
  logic                  samp_q;
  logic [smc_pkg::SMC_EDGE_W-1:0]    edge_q;
  logic [smc_pkg::SMC_DIV_W-1:0]     baud_cnt_q;
  logic [smc_pkg::SMC_DLY_CNT_W-1:0] dly_cnt_q;
  logic                  sclk_q;
  logic [3:0]            cs_q;
  logic                  drv_oe_n_q;
  logic                  miso_oe_n_q;
  logic                  irq_q;
  logic [4:0]            nbits;
  logic [smc_pkg::SMC_EDGE_W-1:0] last_idx;
  logic [smc_pkg::SMC_DIV_W-1:0]  div_m1;
  logic [3:0]            pcs_sel;
  logic                  pcs_ok;
  logic                  start_ok;
  logic                  tick;
  logic                  edge_ev;
  logic                  last_edge;
  logic                  done;
  logic                  lead;
  logic                  din;
  logic                  cs_low_s;
  logic                  cs_fall;
  logic                  dly_zero;
  logic                  dly_done;
  logic                  load_m;
  logic                  load_s;
  logic                  load;
  logic [15:0]           rx_word;
  smc_pkg::smc_status_t  status_now;

  // Transmit words queue here ahead of the holding register.
  smc_fifo #(
    .WIDTH ($bits(smc_pkg::smc_tx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (tx_valid_in),
    .in_data_in    (tx_word_in),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_word),
    .out_ready_in  (fifo_pop)
  );

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q     <= '1;
      sync2_q     <= '1;
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
    end else begin
      sync1_q     <= {cs0_in, sclk_in, mosi_in, miso_in};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sync2_q[IX_SCLK];
      cs_prev_q   <= sync2_q[IX_CS0];
    end
  end

  assign cs_low_s = !sync2_q[IX_CS0];                              // see RL3
  assign cs_fall  = cs_prev_q && cs_low_s;
  assign din      = mst_q ? sync2_q[IX_MISO] : sync2_q[IX_MOSI];   // see RL1 see RL2

  always_comb begin
    nbits = 5'(smc_pkg::SMC_MIN_BITS) + {1'b0, word_bits_in};      // see RL23 see RL24
    if (nbits > smc_pkg::SMC_MAX_BITS) begin
      nbits = smc_pkg::SMC_MAX_BITS;
    end
  end

  assign last_idx  = {nbits, 1'b0} - 1'b1;
  assign div_m1    = (baud_div_in == '0) ? '0 : baud_div_in - 1'b1;
  assign pcs_sel   = peripheral_select_mode_in ? thr_q.peripheral_select_field : mode_select_field_in; // see RL22
  assign pcs_ok    = smc_pkg::smc_cs_decode(pcs_sel) != smc_pkg::SMC_CS_IDLE;       // see RL12
  assign start_ok  = !tx_holding_empty_flag_q && pcs_ok;
  assign tick      = (state_q == smc_pkg::SMC_SHIFT) && (baud_cnt_q >= div_m1);
  assign edge_ev   = enable_in && (mst_q ? (tick && mst_q)
                                        : (cs_low_s && !cs_fall &&
                                           (sync2_q[IX_SCLK] != sclk_prev_q)));
  assign last_edge = edge_q == last_idx;
  assign done      = edge_ev && last_edge;
  assign lead      = !edge_q[0];
  assign dly_zero  = inter_transfer_delay_in == '0;
  assign dly_done  = dly_cnt_q == '0;
  assign rx_word   = smc_pkg::smc_mask({sh_q[14:0], clock_phase_in ? samp_q : din}, nbits);

  assign load_m = enable_in && mst_q && start_ok &&                // see RL10 see RL13
                  ((state_q == smc_pkg::SMC_IDLE) ||
                   ((state_q == smc_pkg::SMC_SHIFT) && done && dly_zero) ||
                   ((state_q == smc_pkg::SMC_DELAY) && dly_done));
  assign load_s = enable_in && !mst_q && !tx_holding_empty_flag_q && (cs_fall || done);
  assign load   = load_m || load_s;
  assign fifo_pop = fifo_valid && tx_holding_empty_flag_q;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mst_q       <= 1'b0;
      drv_oe_n_q  <= 1'b1;
      miso_oe_n_q <= 1'b1;
    end else begin
      mst_q       <= master_select_in;
      drv_oe_n_q  <= !master_select_in;                            // see RL1 see RL3
      miso_oe_n_q <= master_select_in || !cs_low_s;                // see RL2
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= smc_pkg::SMC_IDLE;
    end else if (!enable_in || !mst_q) begin
      state_q <= smc_pkg::SMC_IDLE;
    end else begin
      unique case (state_q)
        smc_pkg::SMC_IDLE: begin
          if (load_m) begin
            state_q <= smc_pkg::SMC_SHIFT;
          end
        end
        smc_pkg::SMC_SHIFT: begin
          if (done && !dly_zero) begin
            state_q <= smc_pkg::SMC_DELAY;
          end else if (done && !load_m) begin
            state_q <= smc_pkg::SMC_IDLE;
          end
        end
        smc_pkg::SMC_DELAY: begin
          if (dly_done) begin
            state_q <= load_m ? smc_pkg::SMC_SHIFT : smc_pkg::SMC_IDLE; // see RL17
          end
        end
      endcase
    end
  end

  // Baud divider; held at zero whenever the core is not clocking as master.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      baud_cnt_q <= '0;
    end else if (!mst_q || state_q != smc_pkg::SMC_SHIFT || tick) begin  // see RL4
      baud_cnt_q <= '0;
    end else begin
      baud_cnt_q <= baud_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dly_cnt_q <= '0;
    end else if (done && mst_q) begin
      dly_cnt_q <= smc_pkg::SMC_DLY_CNT_W'(inter_transfer_delay_in * smc_pkg::SMC_DELAY_UNIT - 1);
    end else if (state_q == smc_pkg::SMC_DELAY && !dly_done) begin
      dly_cnt_q <= dly_cnt_q - 1'b1;
    end
  end

  // Edge counter and serializer shared by both modes.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edge_q <= '0;
      samp_q <= 1'b0;
      sh_q   <= smc_pkg::SMC_SHIFT_RST;
    end else begin
      if (load || cs_fall || done) begin
        edge_q <= '0;
      end else if (edge_ev) begin
        edge_q <= edge_q + 1'b1;
      end
      if (edge_ev && (clock_phase_in ? lead : !lead)) begin        // see RL5 see RL6 see RL7
        samp_q <= din;                                             // see RL11
      end
      if (load) begin
        sh_q <= smc_pkg::smc_align(thr_q.data, nbits);             // see RL9 see RL26
      end else if (done) begin
        sh_q <= rx_word;
      end else if (edge_ev && (clock_phase_in ? !lead : (lead && edge_q != '0))) begin
        sh_q <= {sh_q[14:0], samp_q};                              // see RL11 see RL26
      end
    end
  end

  // Master clock and select pins; clock rests at the polarity level.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_q <= 1'b0;
      cs_q   <= smc_pkg::SMC_CS_IDLE;
    end else begin
      if (state_q == smc_pkg::SMC_SHIFT && edge_ev) begin
        sclk_q <= !sclk_q;                                         // see RL8
      end else if (state_q != smc_pkg::SMC_SHIFT) begin
        sclk_q <= clock_polarity_in;                               // see RL5
      end
      if (load_m) begin
        cs_q <= smc_pkg::smc_cs_decode(pcs_sel);                   // see RL8 see RL22
      end else if (state_q == smc_pkg::SMC_IDLE || !mst_q) begin
        cs_q <= smc_pkg::SMC_CS_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_holding_empty_flag_q <= 1'b1;
      thr_q  <= '0;
    end else if (fifo_pop) begin
      tx_holding_empty_flag_q <= 1'b0;                                              // see RL14
      thr_q  <= fifo_word;
    end else if (load) begin
      tx_holding_empty_flag_q <= 1'b1;                                              // see RL14
    end
  end

  // Receive holding; overrun keeps the old word and blocks further loads.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_q      <= '0;
      rx_full_q <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      if (done && !rx_full_q && !ovr_q) begin
        rx_q <= rx_word;                                           // see RL20
      end
      if (done && !rx_full_q && !ovr_q) begin
        rx_full_q <= 1'b1;                                         // see RL18
      end else if (rx_read_in) begin
        rx_full_q <= 1'b0;
      end
      if (done && (rx_full_q || ovr_q)) begin
        ovr_q <= 1'b1;                                             // see RL19
      end else if (status_read_in) begin
        ovr_q <= 1'b0;                                             // see RL20
      end
    end
  end

  always_comb begin
    status_now.tx_holding_empty = tx_holding_empty_flag_q;
    status_now.tx_idle          = tx_idle_q;
    status_now.rx_full          = rx_full_q;
    status_now.rx_overrun       = ovr_q;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_idle_q <= 1'b1;
      irq_q     <= 1'b0;
    end else begin
      tx_idle_q <= tx_holding_empty_flag_q && !load && (mst_q ? state_q == smc_pkg::SMC_IDLE   // see RL16
                                             : !cs_low_s);
      irq_q     <= |(status_now & irq_enable_in);                  // see RL21 see RL25
    end
  end

  assign rx_data_out    = rx_q;
  assign status_out     = status_now;
  assign irq_out        = irq_q;
  assign dma_tx_req_out = tx_holding_empty_flag_q;                                  // see RL15
  assign sclk_out       = sclk_q;
  assign sclk_oe_n_out  = drv_oe_n_q;
  assign mosi_out       = sh_q[15];
  assign mosi_oe_n_out  = drv_oe_n_q;
  assign miso_out       = sh_q[15];
  assign miso_oe_n_out  = miso_oe_n_q;
  assign cs_out         = cs_q;
  assign cs_oe_n_out    = {smc_pkg::SMC_PCS_W{drv_oe_n_q}};

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_word_done;
    edge_ev && last_edge;
  endsequence

  a_master_pins_drive: assert property (mst_q |-> !sclk_oe_n_out && cs_oe_n_out == '0 // see RL1
    && !mosi_oe_n_out && miso_oe_n_out) else $error("master pins not driven");
  a_slave_pins_free: assert property (!mst_q |-> sclk_oe_n_out && mosi_oe_n_out // see RL3
    && cs_oe_n_out == smc_pkg::SMC_CS_IDLE) else $error("slave drives master pins");
  a_baud_slave_off: assert property (!mst_q |-> baud_cnt_q == '0) // see RL4
    else $error("baud generator runs in slave mode");
  a_sclk_rest_level: assert property (($stable(clock_polarity_in) && mst_q && // see RL5
    state_q == smc_pkg::SMC_IDLE)[*2] |-> sclk_out == clock_polarity_in)
    else $error("serial clock not at polarity level");
  a_no_start_unsel: assert property (state_q == smc_pkg::SMC_IDLE && !pcs_ok // see RL12
    |=> state_q != smc_pkg::SMC_SHIFT) else $error("transfer started without slave");
  a_start_on_write: assert property (enable_in && mst_q && state_q == smc_pkg::SMC_IDLE // see RL10
    && !tx_holding_empty_flag_q && pcs_ok |=> state_q == smc_pkg::SMC_SHIFT && cs_out != smc_pkg::SMC_CS_IDLE)
    else $error("write did not start transfer");
  a_load_sets_empty: assert property (load && !fifo_pop |=> tx_holding_empty_now()) // see RL14
    else $error("holding empty not set on load");
  a_rx_full_load: assert property (s_word_done ##0 (!rx_full_q && !ovr_q) // see RL18
    |=> status_out.rx_full && rx_data_out == $past(rx_word)) else $error("receive not loaded");
  a_overrun_hold: assert property (s_word_done ##0 rx_full_q // see RL19
    |=> status_out.rx_overrun && $stable(rx_data_out)) else $error("overrun not flagged");
  a_irq_follows: assert property (|(status_now & irq_enable_in) |=> irq_out) // see RL25
    else $error("interrupt not raised");
  a_cs_single_low: assert property (state_q == smc_pkg::SMC_SHIFT && mst_q // see RL8
    |-> $onehot(~cs_out)) else $error("chip select not single");

  function automatic logic tx_holding_empty_now();
    return tx_holding_empty_flag_q;
  endfunction

endmodule

// [verilog/smc_fifo.sv]
// Purpose: Word FIFO with a registered output slot.
// Assumes: DEPTH is a power of two.
// Notes:   in_ready_out and out_valid_out are registered.
`timescale 1ns/1ps
module smc_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  assign push = in_valid_in && in_ready_out;
  assign pop  = (count_q != '0) && (!out_valid_out || out_ready_in);

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q     <= '0;
      rd_ptr_q     <= '0;
      count_q      <= '0;
      in_ready_out <= 1'b0;
    end else begin
      wr_ptr_q     <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q     <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_q      <= count_d;
      in_ready_out <= count_d < (AW + 1)'(DEPTH);
    end
  end

  // The output slot refills whenever it is empty or being taken.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem_q[rd_ptr_q];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end

endmodule

// [verilog/smc_pkg.sv]
// Purpose: Shared constants, carriers and helpers for the serial peripheral core.
// Assumes: Word length field counts extra bits above the minimum word of eight.
// Notes:   Chip selects are active low; all ones means no peripheral selected.
package smc_pkg;

  localparam int          SMC_DATA_W     = 16;
  localparam int          SMC_PCS_W      = 4;
  localparam int          SMC_MIN_BITS   = 8;
  localparam int          SMC_BITS_W     = 4;
  localparam int          SMC_DIV_W      = 8;
  localparam int          SMC_DLY_W      = 8;
  localparam int          SMC_DLY_CNT_W  = 13;
  localparam int          SMC_EDGE_W     = 6;
  localparam int          SMC_FIFO_DEPTH = 16;
  localparam int          SMC_SYNC_N     = 4;
  // Inter-transfer delay unit in core clock cycles.
  localparam int          SMC_DELAY_UNIT = 32;
  localparam logic [3:0]  SMC_CS_IDLE    = 4'hF;
  localparam logic [4:0]  SMC_MAX_BITS   = 5'h10;
  localparam logic [15:0] SMC_SHIFT_RST  = 16'h0000;

  typedef struct packed {
    logic [SMC_PCS_W-1:0]  peripheral_select_field;
    logic [SMC_DATA_W-1:0] data;
  } smc_tx_word_t;

  typedef struct packed {
    logic tx_holding_empty;
    logic tx_idle;
    logic rx_full;
    logic rx_overrun;
  } smc_status_t;

  typedef enum logic [1:0] {
    SMC_IDLE,
    SMC_SHIFT,
    SMC_DELAY
  } smc_state_t;

  // Only the lowest numbered low bit of a select field drives its line low.
  function automatic logic [3:0] smc_cs_decode(input logic [3:0] peripheral_select_field);
    logic [3:0] cs;
    cs = SMC_CS_IDLE;
    for (int i = SMC_PCS_W - 1; i >= 0; i--) begin
      if (!peripheral_select_field[i]) begin
        cs = SMC_CS_IDLE;
        cs[i] = 1'b0;
      end
    end
    return cs;
  endfunction

  // Places a word so that its top bit leaves first from bit fifteen.
  function automatic logic [15:0] smc_align(input logic [15:0] data, input logic [4:0] nbits);
    logic [4:0] pad;
    pad = SMC_MAX_BITS - nbits;
    return data << pad;
  endfunction

  function automatic logic [15:0] smc_mask(input logic [15:0] data, input logic [4:0] nbits);
    logic [15:0] keep;
    keep = ~(16'hFFFF << nbits);
    return data & keep;
  endfunction

endpackage
